// File: rtl/sbcs_pkg.sv
// shared constants and types of the synchronous burst cache sram
`default_nettype none
package sbcs_pkg;
    // array geometry
    localparam int unsigned ADDR_W  = 14;
    localparam int unsigned DATA_W  = 64;
    localparam int unsigned LANES   = 8;
    localparam int unsigned LANE_W  = 8;
    localparam int unsigned DEPTH   = 16384;
    localparam int unsigned BURST_W = 2;

    // lane masks
    localparam logic [7:0] LANE_ALL  = 8'hff;
    localparam logic [7:0] LANE_NONE = 8'h00;

    // burst step count values
    localparam logic [1:0] BURST_FIRST = 2'h0;
    localparam logic [1:0] BURST_ONE   = 2'h1;

    // values of pin synchronisers after reset (output enable off)
    localparam logic OE_RST   = 1'h1;
    localparam logic MODE_RST = 1'h0;

    // access state, one-hot
    typedef enum logic [1:0] {
        SBCS_IDLE = 2'b01,
        SBCS_ACT  = 2'b10
    } sbcs_state_t;
endpackage : sbcs_pkg
`default_nettype wire

// File: rtl/sbcs_sram.sv
// access control, burst counter and data path of the burst cache sram
`default_nettype none
// Function
// [R1] every synchronous input is captured in an input register on rising clk
// [R2] pipelined: read data via output register; flow-through: output stage transparent
// [R3] flow-through select high picks flow-through, low picks pipelined
// [R4] 2-bit wraparound burst counter loads first address, makes the rest
// [R5] burst order chosen by sampling the linear-order select input
// [R6] only the burst-step input moves the burst address
// [R7] global write overrides byte enables; all eight lanes written
// [R8] processor strobe ignored while first chip select is high
// [R9] 16K words of 64 bits, 14-bit address, shared data pins
// [R10] strobe low, all selects active, writes high: read starts, address loaded
// [R11] pipelined read data driven from the next rising edge
// [R12] outputs off for the whole first cycle after deselected to selected
// [R13] later cycles drive only while output enable low, via enable registers
// [R14] back-to-back single reads accepted with no idle cycles
// [R15] deselect at a clock rise turns outputs off at once
// [R16] processor-strobe start loads address, ignores write controls and step
// [R17] processor-strobe write takes two clocks; second edge controls decide
// [R18] byte write with global high writes only selected lanes
// [R19] controller-strobe write completes in one clock, step ignored
// [R20] other party raises output enable before driving write data
// [R21] drivers forced off whenever a write cycle is detected
// [R22] writes self-timed inside the clock cycle
// [R23] step low at a rise moves to next burst address, reads and writes
// [R24] counter on two low bits: interleaved xor, linear add one mod four
// [R25] processor-strobe access always begins as a read
// [R26] step high mid-burst holds address; linear order when input low
module sbcs_sram #(
    parameter int unsigned ADDR_W = sbcs_pkg::ADDR_W,
    parameter int unsigned DATA_W = sbcs_pkg::DATA_W,
    parameter int unsigned LANES  = sbcs_pkg::LANES
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // static mode straps
    input  wire logic              flow_through_sel,
    input  wire logic              linear_order_n,
    // address strobes and chip selects
    input  wire logic              cpu_addr_strobe_n,
    input  wire logic              ctrl_addr_strobe_n,
    input  wire logic              chip_sel_a_n,
    input  wire logic              chip_sel_b_n,
    input  wire logic              chip_sel_c_n,
    input  wire logic              chip_sel_d,
    input  wire logic              chip_sel_e,
    // write controls and burst step
    input  wire logic              global_write_n,
    input  wire logic              byte_write_en_n,
    input  wire logic [LANES-1:0]  byte_sel_n,
    input  wire logic              burst_step_n,
    // address
    input  wire logic [ADDR_W-1:0] addr_in,
    // shared data pins, split
    input  wire logic              output_enable_n,
    input  wire logic [DATA_W-1:0] data_io_i,
    output logic      [DATA_W-1:0] data_io_o,
    output logic                   data_io_oe
);

    localparam int unsigned LW = DATA_W / LANES;

    // all control state of the block
    typedef struct packed {
        logic                 ads_p_n;
        logic                 ads_c_n;
        logic                 cs_a_n;
        logic                 cs_b_n;
        logic                 cs_c_n;
        logic                 cs_d;
        logic                 cs_e;
        logic                 gw_n;
        logic                 bwe_n;
        logic [LANES-1:0]     bsel_n;
        logic                 step_n;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    din;
        logic                 ft_m;
        logic                 ft_s;
        logic                 lo_m;
        logic                 lo_s;
        logic                 oe_m;
        logic                 oe_s;
        sbcs_pkg::sbcs_state_t state;
        logic [ADDR_W-1:0]    base;
        logic [1:0]           idx;
        logic                 rd_v1;
        logic                 rd_v2;
        logic [DATA_W-1:0]    out_q;
    } sbcs_regs_t;

    sbcs_regs_t q;
    sbcs_regs_t d;

    // memory side
    logic [DATA_W-1:0] rd_q;
    logic [ADDR_W-1:0] mem_addr;
    logic [LANES-1:0]  mem_we;
    logic              mem_rd;

    // decoded conditions from the input registers
    logic       sel_all;
    logic       cpu_start;
    logic       ctrl_start;
    logic       start;
    logic       desel_now;
    logic       wr_req;
    logic       wr_now;
    logic       active;
    logic [1:0] idx_next;
    logic [1:0] low_bits;
    logic [LANES-1:0] lane_mask;

    // burst low bits from start bits and step count
    function automatic logic [1:0] burst_bits(input logic [1:0] first,
                                              input logic [1:0] k,
                                              input logic       lin);
        logic [1:0] r;
        r = lin ? 2'(first + k) : (first ^ k);   // [R24]
        return r;
    endfunction : burst_bits

    // start and deselect decode, all on registered pins
    always_comb
    begin
        sel_all   = !q.cs_a_n && !q.cs_b_n && !q.cs_c_n && q.cs_d && q.cs_e;
        // first select high masks the processor strobe entirely
        cpu_start = !q.ads_p_n && !q.cs_a_n && sel_all;         // [R8]
        ctrl_start = !q.ads_c_n && sel_all && !cpu_start;
        start     = cpu_start || ctrl_start;
        desel_now = ((!q.ads_p_n && !q.cs_a_n) || !q.ads_c_n) && !sel_all;
        wr_req    = !q.gw_n || (!q.bwe_n && (q.bsel_n != sbcs_pkg::LANE_ALL));
        // global write wins over byte enable and selects
        if (!q.gw_n)
        begin
            lane_mask = sbcs_pkg::LANE_ALL;                     // [R7]
        end
        else if (!q.bwe_n)
        begin
            lane_mask = ~q.bsel_n;                              // [R18]
        end
        else
        begin
            lane_mask = sbcs_pkg::LANE_NONE;
        end
        active = (q.state == sbcs_pkg::SBCS_ACT);
    end

    // next state: address counter, access type, read pipeline
    always_comb
    begin
        d          = q;
        idx_next   = q.idx;
        mem_addr   = q.base;
        mem_we     = sbcs_pkg::LANE_NONE;
        mem_rd     = 1'b0;
        wr_now     = 1'b0;
        low_bits   = 2'h0;
        // input registers on every edge
        d.ads_p_n  = cpu_addr_strobe_n;                          // [R1]
        d.ads_c_n  = ctrl_addr_strobe_n;
        d.cs_a_n   = chip_sel_a_n;
        d.cs_b_n   = chip_sel_b_n;
        d.cs_c_n   = chip_sel_c_n;
        d.cs_d     = chip_sel_d;
        d.cs_e     = chip_sel_e;
        d.gw_n     = global_write_n;
        d.bwe_n    = byte_write_en_n;
        d.bsel_n   = byte_sel_n;
        d.step_n   = burst_step_n;
        d.addr     = addr_in;
        d.din      = data_io_i;
        // straps and the asynchronous enable pass two flops
        d.ft_m     = flow_through_sel;
        d.ft_s     = q.ft_m;
        d.lo_m     = linear_order_n;
        d.lo_s     = q.lo_m;
        d.oe_m     = output_enable_n;                            // [R13]
        d.oe_s     = q.oe_m;
        d.rd_v2    = q.rd_v1;
        d.rd_v1    = 1'b0;
        d.out_q    = rd_q;                                       // [R11]
        case (1'b1)
            start:
            begin
                // new access: address straight from the pins
                d.state  = sbcs_pkg::SBCS_ACT;
                d.base   = q.addr;                               // [R10]
                d.idx    = sbcs_pkg::BURST_FIRST;                // [R4]
                mem_addr = q.addr;
                if (ctrl_start && wr_req)
                begin
                    // one-cycle write, step not looked at
                    mem_we = lane_mask;                          // [R19]
                    wr_now = 1'b1;
                end
                else
                begin
                    // processor start is a read whatever the controls say
                    mem_rd  = 1'b1;                              // [R25] [R16]
                    d.rd_v1 = 1'b1;                              // [R14]
                end
            end
            desel_now:
            begin
                // drop the pipeline so nothing drives later
                d.state = sbcs_pkg::SBCS_IDLE;                   // [R15]
                d.rd_v1 = 1'b0;
                d.rd_v2 = 1'b0;
            end
            active:
            begin
                // continue or suspend: only the step input moves it
                idx_next = q.step_n ? q.idx
                                    : 2'(q.idx + sbcs_pkg::BURST_ONE); // [R6]
                low_bits = burst_bits(q.base[1:0], idx_next, !q.lo_s); // [R5]
                mem_addr = {q.base[ADDR_W-1:2], low_bits};       // [R23]
                d.idx    = idx_next;                             // [R26]
                if (wr_req)
                begin
                    // second edge of a processor write lands here
                    mem_we = lane_mask;                          // [R17]
                    wr_now = 1'b1;
                end
                else
                begin
                    mem_rd  = 1'b1;
                    d.rd_v1 = 1'b1;
                end
            end
            default:
            begin
                d.state = q.state;
            end
        endcase
    end

    // single register for all control state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q       <= '0;
            q.state <= sbcs_pkg::SBCS_IDLE;
            q.oe_m  <= sbcs_pkg::OE_RST;
            q.oe_s  <= sbcs_pkg::OE_RST;
            q.ft_m  <= sbcs_pkg::MODE_RST;
            q.ft_s  <= sbcs_pkg::MODE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // core array, one bank per lane so every bank has a single writer;
    // writes finish within the edge, no pulse needed; banks not reset
    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++)
        begin : g_lane
            logic [LW-1:0] bank [0:(1<<ADDR_W)-1];

            always_ff @(posedge clk_sys)
            begin
                if (mem_we[gl])
                begin
                    bank[mem_addr] <= q.din[gl*LW +: LW];        // [R22]
                end
                if (mem_rd)
                begin
                    rd_q[gl*LW +: LW] <= bank[mem_addr];         // [R9]
                end
            end
        end
    endgenerate

    // output stage: flow-through bypasses the output register
    assign data_io_o  = q.ft_s ? rd_q : q.out_q;                 // [R2] [R3]
    // drive only with valid data, enable low, no write and no deselect
    assign data_io_oe = (q.ft_s ? q.rd_v1 : q.rd_v2) && !q.oe_s
                        && !wr_now && !desel_now                 // [R21] [R15]
                        && !(start && !active);                  // [R12]

    // checks
    sequence s_read_issue;
        mem_rd && !q.ft_s;
    endsequence

    sequence s_cpu_then_write;
        cpu_start ##1 (!start && !desel_now && wr_req);
    endsequence

    a_oe_off_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R21]
        wr_now |-> !data_io_oe)
        else $error("drivers on during a write");

    a_oe_off_desel: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
        desel_now |-> !data_io_oe)
        else $error("drivers on during deselect");

    a_first_cycle_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
        (start && !active) |-> !data_io_oe)
        else $error("drivers on in first access cycle");

    a_oe_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
        data_io_oe |-> (!q.oe_s && !$past(output_enable_n, 2)))
        else $error("drivers on with output enable high");

    a_burst_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R26]
        (active && !start && !desel_now && q.step_n) |=> $stable(q.idx))
        else $error("burst index moved without step");

    a_burst_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R23]
        (active && !start && !desel_now && !q.step_n)
        |=> (q.idx == 2'($past(q.idx) + 2'h1)))
        else $error("burst index did not advance");

    a_gw_all_lanes: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        (wr_now && !q.gw_n) |-> (mem_we == sbcs_pkg::LANE_ALL))
        else $error("global write missed a lane");

    a_byte_lanes: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R18]
        (wr_now && q.gw_n) |-> (mem_we == ~q.bsel_n))
        else $error("byte write lanes wrong");

    a_cpu_reads: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R25]
        cpu_start |-> (mem_we == sbcs_pkg::LANE_NONE && mem_rd))
        else $error("processor start did not read");

    a_cpu_write_two: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R17]
        s_cpu_then_write |-> (mem_we != sbcs_pkg::LANE_NONE
                              && mem_addr == q.base))
        else $error("processor write not done on second edge");

    a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R19]
        (ctrl_start && wr_req) |-> (mem_addr == q.addr && mem_we == lane_mask))
        else $error("controller write not done in one clock");

    a_pipe_latency: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
        s_read_issue ##1 !desel_now |=> (q.rd_v2 && data_io_o == $past(rd_q)))
        else $error("pipelined data not ready next edge");

    a_addr_load: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
        start |=> (q.base == $past(q.addr) && q.idx == 2'h0))
        else $error("start address not loaded");

    a_cs1_masks: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
        (q.cs_a_n && q.ads_c_n) |-> !start)
        else $error("processor strobe taken with first select high");

endmodule : sbcs_sram
`default_nettype wire

// File: verif/sbcs_host_model.sv
// host side of the shared data pins: write driver and wire resolution
`default_nettype none
module sbcs_host_model (
    // clock
    input  wire logic        clk_sys,
    // host wishes
    input  wire logic        host_oe_n,
    input  wire logic        drv_en,
    input  wire logic [63:0] drv_data,
    // device side of the pins
    input  wire logic [63:0] dev_o,
    input  wire logic        dev_oe,
    output logic             output_enable_n,
    output logic      [63:0] bus
);
    logic [63:0] last_q;

    // enable forced off whenever the host drives write data
    assign output_enable_n = host_oe_n | drv_en;

    // clash shows as unknown; a floating wire never keeps its last value
    always_comb
    begin
        if (dev_oe && drv_en)
            bus = 'x;
        else if (dev_oe)
            bus = dev_o;
        else if (drv_en)
            bus = drv_data;
        else
            bus = ~last_q;
    end

    always_ff @(posedge clk_sys)
        last_q <= bus;
endmodule : sbcs_host_model
`default_nettype wire

// File: verif/test_sync_burst_cache_sram.sv
// self-checking bench of the burst cache sram
`default_nettype none
module test_sync_burst_cache_sram;
timeunit 1ns;
timeprecision 1ns;
typedef struct {logic [63:0] d; int c;} sbcs_exp_t;
logic        clk_sys = 0, rst_n = 0, ft = 0, lin_n = 1;
logic        p_n = 1, c_n = 1, gw_n = 1, bw_n = 1, st_n = 1;
logic [7:0]  bs_n = 8'hff;
logic [4:0]  cs_off = 5'h00;
logic [13:0] addr = 14'h0000;
logic [13:0] ad [8];
logic [63:0] din = 64'h0, d_o, d_i;
logic        d_oe, oe_n, host_oe_n = 0, drv_en = 0;
logic [63:0] mem_m [int];
sbcs_exp_t   exp_q [$];
int          fail_count = 0, checks = 0, cnt = 0;

always #50 clk_sys = ~clk_sys;

sbcs_sram dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .flow_through_sel(ft),
    .linear_order_n(lin_n), .cpu_addr_strobe_n(p_n),
    .ctrl_addr_strobe_n(c_n), .chip_sel_a_n(cs_off[0]),
    .chip_sel_b_n(cs_off[1]), .chip_sel_c_n(cs_off[2]),
    .chip_sel_d(~cs_off[3]), .chip_sel_e(~cs_off[4]),
    .global_write_n(gw_n), .byte_write_en_n(bw_n), .byte_sel_n(bs_n),
    .burst_step_n(st_n), .addr_in(addr), .output_enable_n(oe_n),
    .data_io_i(d_i), .data_io_o(d_o), .data_io_oe(d_oe));

sbcs_host_model host_u (.clk_sys(clk_sys), .host_oe_n(host_oe_n),
    .drv_en(drv_en), .drv_data(din), .dev_o(d_o), .dev_oe(d_oe),
    .output_enable_n(oe_n), .bus(d_i));

task automatic check(input string nm, input logic [63:0] e, s);
    checks++;
    if (s !== e)
    begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", nm, e, s);
    end
endtask : check

task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask : stop_test

// one pin cycle; a deselect drops reads still inside the pipe
task automatic drive(input logic p, c, g, w, input logic [7:0] b,
    input logic s, input logic [4:0] cs, input logic [13:0] a,
    input logic [63:0] d, input logic de);
    @(posedge clk_sys);
    p_n <= p;
    c_n <= c;
    gw_n <= g;
    bw_n <= w;
    bs_n <= b;
    st_n <= s;
    cs_off <= cs;
    addr <= a;
    din <= d;
    drv_en <= de;
    while (cs != 5'h00 && exp_q.size() != 0 && exp_q[$].c > cnt + 1)
        void'(exp_q.pop_back());
endtask : drive

// expected array contents after a write
function automatic void upd(input logic [13:0] a, input logic [63:0] d,
    input logic g, w, input logic [7:0] b);
    logic [63:0] m;
    m = mem_m[a];
    for (int i = 0; i < 8; i++)
        if (!g || (!w && !b[i]))
            m[8*i +: 8] = d[8*i +: 8];
    mem_m[a] = m;
endfunction : upd

task automatic wr_c(input logic [13:0] a, input logic g, w,
    input logic [7:0] b);
    logic [63:0] d;
    d = {$urandom, $urandom};
    upd(a, d, g, w, b);
    drive(1, 0, g, w, b, 0, 5'h00, a, d, 1);
endtask : wr_c

// read cycle; ea is the address of the word the array should return
task automatic rd(input logic p, c, s, input logic [13:0] a, ea);
    drive(p, c, 1, 1, 8'hff, s, 5'h00, a, 64'h0, 0);
    exp_q.push_back('{mem_m[ea], cnt + (ft ? 3 : 4)});
endtask : rd

task automatic idle(input int n);
    repeat (n) drive(1, 0, 1, 1, 8'hff, 1, 5'h08, 14'($urandom), 64'h0, 0);
endtask : idle

// outputs may only rise when a read result is due
always @(negedge clk_sys)
begin
    sbcs_exp_t e;
    cnt++;
    if (exp_q.size() != 0 && exp_q[0].c < cnt)
    begin
        e = exp_q.pop_front();
        check("data_io_oe", 1, d_oe);
    end
    else if (d_oe === 1'b1 && exp_q.size() == 0)
        check("data_io_oe", 0, 1);
    else if (d_oe === 1'b1)
    begin
        e = exp_q.pop_front();
        check("read data", e.d, d_o);
        check("read cycle", 64'(e.c), 64'(cnt));
    end
    else if (d_oe !== 1'b0)
        check("data_io_oe", 0, d_oe);
end

initial
begin
    repeat (20000) @(posedge clk_sys);
    check("run time", 0, 1);
    stop_test();
end

initial
begin
    logic [1:0] s, k;
    logic [13:0] a;
    void'($urandom(48));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1;
    idle(4);
    // global and byte writes, then back-to-back reads
    for (int i = 0; i < 8; i++)
    begin
        ad[i] = 14'($urandom);
        wr_c(ad[i], 0, 1, 8'hff);
    end
    for (int i = 0; i < 8; i++)
        wr_c(ad[i], i[0], 0, 8'($urandom));
    for (int i = 0; i < 8; i++)
        rd(1, 0, 1, ad[i], ad[i]);
    repeat (4) rd(1, 1, 1, 14'($urandom), ad[7]);
    idle(6);
    $display("test writes_and_reads done");
    // processor write: start is a read, second edge writes
    host_oe_n <= 1;
    idle(3);
    din <= 64'h0;
    drive(0, 1, 0, 0, 8'h00, 0, 5'h00, ad[0], 64'h0, 0);
    a = 14'($urandom);
    s = 2'($urandom);
    upd(ad[0], {$urandom, $urandom}, 1, 0, {6'h3f, s});
    drive(1, 1, 1, 0, {6'h3f, s}, 1, 5'h00, a, mem_m[ad[0]] ^ 64'h0, 1);
    idle(2);
    host_oe_n <= 0;
    idle(3);
    rd(1, 0, 1, ad[0], ad[0]);
    repeat (4) rd(1, 1, 1, a, ad[0]);
    idle(6);
    $display("test processor_write done");
    // each select off cuts a read; processor strobe ignored on select a
    for (int i = 0; i < 5; i++)
    begin
        drive(1, 0, 1, 1, 8'hff, 1, 5'h00, ad[i], 64'h0, 0);
        drive(1, 0, 1, 1, 8'hff, 1, 5'(1 << i), ad[i], 64'h0, 0);
        idle(6);
    end
    drive(0, 1, 1, 1, 8'hff, 1, 5'h01, ad[0], 64'h0, 0);
    idle(6);
    $display("test selects done");
    // bursts in both output modes and both orders, one suspend
    for (int m = 0; m < 2; m++)
        for (int o = 0; o < 2; o++)
        begin
            ft <= m[0];
            lin_n <= o[0];
            idle(4);
            a = 14'($urandom) & 14'h3ffc;
            s = 2'($urandom);
            for (int i = 0; i < 4; i++)
                wr_c(a | 14'(i), 0, 1, 8'hff);
            rd(0, 1, 0, a | 14'(s), a | 14'(s));
            k = 2'h0;
            for (int j = 0; j < 6; j++)
            begin
                if (j != 2)
                    k++;
                rd(1, 1, j == 2, 14'($urandom),
                    a | 14'(o[0] ? s ^ k : 2'(s + k)));
            end
            idle(6);
            $display("test burst mode %0d order %0d done", m, o);
        end
    idle(4);
    check("pending reads", 0, 64'(exp_q.size()));
    stop_test();
end
endmodule : test_sync_burst_cache_sram
`default_nettype wire
